// ==== apm_pkg.sv ====
package apm_pkg;
    // route field codes in encoding order: mute, same side, other side
    typedef enum logic [1:0] {
        APM_ROUTE_MUTE,
        APM_ROUTE_SAME,
        APM_ROUTE_SWAP,
        APM_ROUTE_RSVD
    } apm_route_t;
    // one audio word
    typedef logic [23:0] apm_word_t;
    // bit position inside a half frame
    typedef logic [9:0] apm_pos_t;
endpackage

// ==== apm_regs.svh ====
`ifndef APM_REGS_SVH
`define APM_REGS_SVH

// register indices; byte address is four times the index
`define APM_IDX_OFFSET_LOW 8'h34
`define APM_IDX_ROUTE 8'h35
`define APM_IDX_RATE_MON 8'h37
`define APM_IDX_RATIO_MON 8'h38
`define APM_IDX_OFFSET_HIGH 8'h3A
`define APM_IDX_IRQ_STATUS 8'h3B
`define APM_IDX_IRQ_MASK 8'h3C

// reset values
`define APM_RST_OFFSET_LOW 8'h00
`define APM_RST_ROUTE 8'h11
`define APM_RST_OFFSET_HIGH 1'h0
`define APM_RST_IRQ_MASK 3'h0

// field positions
`define APM_LEFT_LSB 4
`define APM_RIGHT_LSB 0
`define APM_RATIO_HI_LSB 4
`define APM_INVALID_BIT 4

// detected rate codes
`define APM_RATE_ERR 4'h0
`define APM_RATE_32K 4'h6
`define APM_RATE_48K 4'h9
`define APM_RATE_96K 4'hB

// bit clock ratio span
`define APM_RATIO_MIN 10'h020
`define APM_RATIO_MAX 10'h200

// interrupt event bits
`define APM_EV_RATIO 0
`define APM_EV_RATE 1
`define APM_EV_INVALID 2

// timing
`define APM_WORD_BITS 24
`define APM_CLK_NS 50
`define APM_FRAME_32K_NS 31250
`define APM_FRAME_48K_NS 20833
`define APM_FRAME_96K_NS 10417

`endif

// ==== apm_src.sv ====
`timescale 1ns/1ns
// audio source model: drives frames, samples the returned stream
module apm_src (
    // frame shape and content
    input wire logic [9:0] half_in,
    input wire logic [8:0] offset_in,
    input wire logic [23:0] left_in,
    input wire logic [23:0] right_in,
    // returned stream
    input wire logic data_back_in,
    // link pins
    output logic bit_clock_out,
    output logic frame_clock_out,
    output logic data_out,
    // words seen on the returned stream
    output logic [23:0] cap_left_out,
    output logic [23:0] cap_right_out
);
    int hb, off, p, h; // shape, latched at frame start only
    logic [23:0] w, sh; // word sent and word gathered
    // one pass per frame; pins change on bit clock falls
    initial begin
        bit_clock_out = 1'b0;
        frame_clock_out = 1'b1;
        data_out = 1'b0;
        cap_left_out = 24'h000000;
        cap_right_out = 24'h000000;
        sh = 24'h000000;
        // clock stands still until the first frame
        #1000;
        forever begin
            hb = half_in;
            off = offset_in;
            for (h = 0; h < 2; h++) begin
                w = (h == 0) ? left_in : right_in;
                for (p = 0; p < hb; p++) begin
                    frame_clock_out = (h == 1);
                    // outside the word the line toggles, never rests
                    if (p >= off && p < off + 24) begin
                        data_out = w[23 - (p - off)];
                    end else begin
                        data_out = p[0];
                    end
                    #200 bit_clock_out = 1'b1;
                    if (p >= off && p < off + 24) begin
                        sh = {sh[22:0], data_back_in};
                    end
                    #200 bit_clock_out = 1'b0;
                end
                // word seen in this half
                if (h == 0) begin
                    cap_left_out = sh;
                end else begin
                    cap_right_out = sh;
                end
            end
        end
    end
endmodule // apm_src

// ==== apm_sync.sv ====
`timescale 1ns/1ns
// two-flop synchroniser for the three serial pins
module apm_sync (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // asynchronous pins
    input wire logic [2:0] pins_in,
    // synchronised copies
    output logic [2:0] pins_out
);
    logic [2:0] meta_r; // first stage, read only by second stage

    // first stage
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= 3'h0;
        end else begin
            meta_r <= pins_in;
        end
    end

    // second stage
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pins_out <= 3'h0;
        end else begin
            pins_out <= meta_r;
        end
    end
endmodule // apm_sync

// ==== apm_top.sv ====
`timescale 1ns/1ns
`include "apm_regs.svh"
//Contract
// - offset applies to receive and transmit
// - code zero no delay, each step one bit
// - left route mute, left, or right
// - right route mute, right, or left
// - route fields reset to code 01
// - report rate code 0, 6, 9, B
// - ratio ten bits split over two registers
// - ratio counts bit clocks per frame
// - ratio monitor spans 32 to 512
// - invalid unless stable and in span
module apm_top
    import apm_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // serial audio link
    input wire logic bit_clock_in,
    input wire logic frame_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // status
    output logic bck_invalid_out,
    output logic irq_out
);
    // frame period windows in clock cycles, sixteenth tolerance
    localparam int P32 = `APM_FRAME_32K_NS / `APM_CLK_NS;
    localparam int P48 = `APM_FRAME_48K_NS / `APM_CLK_NS;
    localparam int P96 = `APM_FRAME_96K_NS / `APM_CLK_NS;
    localparam logic [10:0] CYC_MAX = 11'h7FF;

    logic [2:0] pins_s; // synchronised bck, frame clock, data
    logic bck_s;
    logic lrck_s;
    logic din_s;
    logic bck_d_r; // bck one cycle ago
    logic bck_rise;
    logic bck_fall;
    logic lrck_d_r; // frame clock seen at last bck rise
    logic half_start; // frame clock changed at this rise
    logic frame_start; // left half begins
    logic frame_start_d_r; // one cycle after frame start
    apm_pos_t pos_r; // position of last received bit
    apm_pos_t rx_pos;
    apm_pos_t tx_pos;
    logic tx_chan; // half being transmitted, 1 right
    logic [9:0] off_full; // nine-bit offset, zero padded
    logic rx_win;
    logic tx_win;
    apm_pos_t rx_d;
    apm_pos_t tx_d;
    apm_word_t shift_r; // receive shifter
    apm_word_t left_word_r; // last received left word
    apm_word_t right_word_r; // last received right word
    apm_word_t tx_left_r; // routed word for left output
    apm_word_t tx_right_r; // routed word for right output
    logic [7:0] offset_lo_r;
    logic offset_hi_r;
    logic [7:0] route_r;
    apm_route_t left_sel;
    apm_route_t right_sel;
    logic [10:0] cyc_cnt_r; // clock cycles in current frame
    logic [10:0] period_r; // cycles in last full frame
    logic [9:0] bck_cnt_r; // bit clocks in current frame
    logic [9:0] ratio_r; // bit clocks in last frame
    logic [9:0] ratio_prev_r; // frame before that
    logic [3:0] rate_code_r;
    logic [3:0] rate_code_nxt;
    logic invalid_nxt;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic apb_setup; // access phase, answer not yet given
    logic apb_done; // transfer completes at this edge
    logic [7:0] idx;
    logic hit;
    logic [31:0] rd_data;

    assign bck_s = pins_s[2];
    assign lrck_s = pins_s[1];
    assign din_s = pins_s[0];

    // pins cross into the clock domain here
    apm_sync u_sync (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .pins_in({bit_clock_in, frame_clock_in, serial_data_in}),
        .pins_out(pins_s)
    );

    // bit clock edge detection on the synchronised copy
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bck_d_r <= 1'b0;
        end else begin
            bck_d_r <= bck_s;
        end
    end
    assign bck_rise = bck_s & ~bck_d_r;
    assign bck_fall = ~bck_s & bck_d_r;
    assign half_start = bck_rise && (lrck_s != lrck_d_r);
    assign frame_start = half_start && !lrck_s;

    assign off_full = {1'b0, offset_hi_r, offset_lo_r};
    assign left_sel = apm_route_t'(route_r[`APM_LEFT_LSB +: 2]);
    assign right_sel = apm_route_t'(route_r[`APM_RIGHT_LSB +: 2]);

    // window opens offset bits after half start
    always_comb begin
        rx_pos = half_start ? 10'h000 : pos_r + 10'h001;
        rx_d = rx_pos - off_full;
        rx_win = (rx_pos >= off_full) && (rx_d < 10'(`APM_WORD_BITS));
    end

    // next transmitted position, decided at the falling edge
    always_comb begin
        if (lrck_s != lrck_d_r) begin
            tx_pos = 10'h000;
            tx_chan = lrck_s;
        end else begin
            tx_pos = pos_r + 10'h001;
            tx_chan = lrck_d_r;
        end
        tx_d = tx_pos - off_full;
        tx_win = (tx_pos >= off_full) && (tx_d < 10'(`APM_WORD_BITS));
    end

    // bit position and frame clock phase, saturating long halves
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pos_r <= 10'h000;
            lrck_d_r <= 1'b0;
        end else if (bck_rise) begin
            lrck_d_r <= lrck_s;
            if (half_start) begin
                pos_r <= 10'h000;
            end else if (pos_r != 10'h3FF) begin
                pos_r <= pos_r + 10'h001;
            end
        end
    end

    // receive shifter takes only the offset window
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_r <= 24'h000000;
            left_word_r <= 24'h000000;
            right_word_r <= 24'h000000;
        end else if (half_start) begin
            // close the half that just ended
            if (lrck_d_r) begin
                right_word_r <= shift_r;
            end else begin
                left_word_r <= shift_r;
            end
            shift_r <= rx_win ? {23'h000000, din_s} : 24'h000000;
        end else if (bck_rise && rx_win) begin
            shift_r <= {shift_r[22:0], din_s};
        end
    end

    // routing waits one cycle so the right word just closed is used
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_start_d_r <= 1'b0;
        end else begin
            frame_start_d_r <= frame_start;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_left_r <= 24'h000000;
        end else if (frame_start_d_r) begin
            case (left_sel)
                APM_ROUTE_SAME: tx_left_r <= left_word_r;
                APM_ROUTE_SWAP: tx_left_r <= right_word_r;
                // mute, and the reserved code behaves as mute
                default: tx_left_r <= 24'h000000;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_right_r <= 24'h000000;
        end else if (frame_start_d_r) begin
            case (right_sel)
                APM_ROUTE_SAME: tx_right_r <= right_word_r;
                APM_ROUTE_SWAP: tx_right_r <= left_word_r;
                default: tx_right_r <= 24'h000000;
            endcase
        end
    end

    // transmit on the falling edge, same offset window
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            serial_data_out <= 1'b0;
        end else if (bck_fall) begin
            if (!tx_win) begin
                serial_data_out <= 1'b0;
            end else if (tx_chan) begin
                serial_data_out <= tx_right_r[5'(23 - tx_d)];
            end else begin
                serial_data_out <= tx_left_r[5'(23 - tx_d)];
            end
        end
    end

    // count bit clocks and clock cycles per frame
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bck_cnt_r <= 10'h000;
            cyc_cnt_r <= 11'h000;
            period_r <= CYC_MAX;
            ratio_r <= 10'h000;
            ratio_prev_r <= 10'h000;
        end else if (frame_start) begin
            ratio_r <= bck_cnt_r;
            ratio_prev_r <= ratio_r;
            period_r <= cyc_cnt_r;
            bck_cnt_r <= 10'h001;
            cyc_cnt_r <= 11'h001;
        end else begin
            // saturation keeps a lost clock from wrapping back in range
            if (bck_rise && bck_cnt_r != 10'h3FF) begin
                bck_cnt_r <= bck_cnt_r + 10'h001;
            end
            if (cyc_cnt_r != CYC_MAX) begin
                cyc_cnt_r <= cyc_cnt_r + 11'h001;
            end
        end
    end

    // classify frame period; tolerance absorbs bck jitter and any other period deviation up to a sixteenth
    function automatic logic [3:0] classify(input logic [10:0] p);
        if (p >= 11'(P32 - P32 / 16) && p <= 11'(P32 + P32 / 16)) begin
            return `APM_RATE_32K;
        end else if (p >= 11'(P48 - P48 / 16) && p <= 11'(P48 + P48 / 16))
        begin
            return `APM_RATE_48K;
        end else if (p >= 11'(P96 - P96 / 16) && p <= 11'(P96 + P96 / 16))
        begin
            return `APM_RATE_96K;
        end else begin
            return `APM_RATE_ERR;
        end
    endfunction

    // monitors refresh every cycle from the measurements
    always_comb begin
        // a stalled frame clock reads as rate error
        rate_code_nxt = (cyc_cnt_r == CYC_MAX) ? `APM_RATE_ERR
                                               : classify(period_r);
        // stable and inside the span, and clock present
        invalid_nxt = (ratio_r != ratio_prev_r)
                   || (ratio_r < `APM_RATIO_MIN)
                   || (ratio_r > `APM_RATIO_MAX)
                   || (cyc_cnt_r == CYC_MAX);
    end

    // monitor state
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rate_code_r <= `APM_RATE_ERR;
            bck_invalid_out <= 1'b1;
        end else begin
            rate_code_r <= rate_code_nxt;
            bck_invalid_out <= invalid_nxt;
        end
    end

    // apb decode; answer comes one cycle into the access phase
    assign apb_setup = psel_in && penable_in && !pready_out;
    assign apb_done = psel_in && penable_in && pready_out;
    assign idx = paddr_in[9:2];

    // ratio split over two monitor registers
    always_comb begin
        hit = 1'b1;
        rd_data = 32'h00000000;
        case (idx)
            `APM_IDX_OFFSET_LOW: rd_data[7:0] = offset_lo_r;
            `APM_IDX_ROUTE: rd_data[7:0] = route_r;
            `APM_IDX_RATE_MON: begin
                rd_data[3:0] = rate_code_r;
                rd_data[`APM_RATIO_HI_LSB +: 2] = ratio_r[9:8];
            end
            `APM_IDX_RATIO_MON: rd_data[7:0] = ratio_r[7:0];
            `APM_IDX_OFFSET_HIGH: begin
                rd_data[0] = offset_hi_r;
                rd_data[`APM_INVALID_BIT] = bck_invalid_out;
            end
            `APM_IDX_IRQ_STATUS: rd_data[2:0] = irq_status_r;
            `APM_IDX_IRQ_MASK: rd_data[2:0] = irq_mask_r;
            default: hit = 1'b0;
        endcase
    end

    // apb answer registers
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= apb_setup;
            pslverr_out <= apb_setup && !hit;
            if (apb_setup) begin
                prdata_out <= pwrite_in ? 32'h00000000 : rd_data;
            end
        end
    end

    // writable registers; monitor indices simply ignore writes
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            offset_lo_r <= `APM_RST_OFFSET_LOW;
            offset_hi_r <= `APM_RST_OFFSET_HIGH;
            route_r <= `APM_RST_ROUTE;
            irq_mask_r <= `APM_RST_IRQ_MASK;
        end else if (apb_done && pwrite_in) begin
            case (idx)
                `APM_IDX_OFFSET_LOW: offset_lo_r <= pwdata_in[7:0];
                `APM_IDX_OFFSET_HIGH: offset_hi_r <= pwdata_in[0];
                // code 11 is stored but only ever mutes
                `APM_IDX_ROUTE: route_r <= pwdata_in[7:0] & 8'h33;
                `APM_IDX_IRQ_MASK: irq_mask_r <= pwdata_in[2:0];
                default: ;
            endcase
        end
    end

    // interrupt events; a set in the clearing cycle survives
    always_comb begin
        irq_set = 3'h0;
        irq_set[`APM_EV_RATIO] = frame_start_d_r && (ratio_r != ratio_prev_r);
        irq_set[`APM_EV_RATE] = rate_code_nxt != rate_code_r;
        irq_set[`APM_EV_INVALID] = invalid_nxt && !bck_invalid_out;
        // clear only the bits handed out, so a late event is not lost
        irq_clr = (apb_done && !pwrite_in && idx == `APM_IDX_IRQ_STATUS)
                ? prdata_out[2:0] : 3'h0;
    end

    // sticky status and the level interrupt
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_status_r <= 3'h0;
            irq_out <= 1'b0;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
            irq_out <= |(irq_status_r & irq_mask_r);
        end
    end

    // checks on the block's own behaviour
    sequence s_read_ratio;
        apb_setup && !pwrite_in && idx == `APM_IDX_RATIO_MON;
    endsequence
    sequence s_route_frame;
        frame_start ##1 frame_start_d_r;
    endsequence

    a_route_reset: assert property (
        @(posedge clock_in) $rose(rstn_in) |-> route_r == `APM_RST_ROUTE)
        else $error("route reset value wrong");
    a_left_swap: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        s_route_frame ##0 (left_sel == APM_ROUTE_SWAP)
        |=> tx_left_r == $past(right_word_r))
        else $error("left output not fed from right input");
    a_left_mute: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        s_route_frame ##0 (left_sel == APM_ROUTE_MUTE) |=> tx_left_r == 0)
        else $error("left output not muted");
    a_right_same: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        s_route_frame ##0 (right_sel == APM_ROUTE_SAME)
        |=> tx_right_r == $past(right_word_r))
        else $error("right output not fed from right input");
    a_offset_gap: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        bck_fall && (tx_pos < off_full) |=> serial_data_out == 1'b0)
        else $error("data driven before offset");
    a_offset_msb: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        bck_fall && !tx_chan && (tx_pos == off_full)
        |=> serial_data_out == $past(tx_left_r[23]))
        else $error("msb not at offset position");
    a_ratio_latch: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        frame_start |=> ratio_r == $past(bck_cnt_r) ##1 $stable(ratio_r))
        else $error("ratio not latched at frame start");
    a_ratio_read: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        s_read_ratio |=> prdata_out == {24'h000000, $past(ratio_r[7:0])})
        else $error("ratio low byte read wrong");
    a_valid_span: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        !bck_invalid_out |-> $past(ratio_r) >= `APM_RATIO_MIN
                          && $past(ratio_r) <= `APM_RATIO_MAX)
        else $error("valid flag with ratio outside span");
    a_rate_codes: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        rate_code_r inside {`APM_RATE_ERR, `APM_RATE_32K,
                            `APM_RATE_48K, `APM_RATE_96K})
        else $error("reserved rate code reported");
    a_irq_level: assert property (
        @(posedge clock_in) disable iff (!rstn_in)
        |(irq_status_r & irq_mask_r) |=> irq_out)
        else $error("interrupt not raised for unmasked status");
endmodule // apm_top

// ==== testbench.sv ====
`timescale 1ns/1ns
// bench: apb register access plus frames from the source model
module testbench;
    logic clk, rstn, psel, pen, pwr, prdy, perr, lerr; // bus side
    logic bitclk, frclk, sdi, sdo, inval, irq; // link and status
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] half; // bit clocks per half frame
    logic [8:0] off; // offset used by the source
    logic [23:0] lw, rw, capl, capr;
    logic [7:0] rt; // route value written
    logic [7:0] tab [3] = '{8'h00, 8'hEE, 8'h12};
    int n_mismatch, num_checks;

    apm_top uut (.clock_in(clk), .rstn_in(rstn), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy),
        .pslverr_out(perr), .bit_clock_in(bitclk), .frame_clock_in(frclk),
        .serial_data_in(sdi), .serial_data_out(sdo),
        .bck_invalid_out(inval), .irq_out(irq));
    apm_src src (.half_in(half), .offset_in(off), .left_in(lw),
        .right_in(rw), .data_back_in(sdo), .bit_clock_out(bitclk),
        .frame_clock_out(frclk), .data_out(sdi), .cap_left_out(capl),
        .cap_right_out(capr));

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // a hung slave is left to the watchdog
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        q = prdata;
        lerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk($sformatf("reg %h", a), e, q);
        chk("slverr", 0, lerr);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("wr slverr", 0, lerr);
    endtask

    // expected channel feed for a route code
    function automatic logic [23:0] pick(input logic [1:0] c,
                                         input logic [23:0] s, o);
        case (c)
            2'b01: return s;
            2'b10: return o;
            default: return 24'h000000;
        endcase
    endfunction

    // let the pipeline settle, then compare both returned words
    task automatic audio();
        repeat (4) @(negedge frclk);
        chk("left out", pick(rt[5:4], lw, rw), capl);
        chk("right out", pick(rt[1:0], rw, lw), capr);
    endtask

    // watchdog, well beyond the expected 1.3 ms
    initial begin
        #3000000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        {rstn, psel, pen, pwr, lerr} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        half = 10'd26;
        off = 9'd0;
        lw = 24'hA5C30F;
        rw = 24'h3C5A96;
        rt = 8'h11;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        wr(12'hF0, 32'h2);
        chk("irq", 0, irq);
        rd(12'hD0, 32'h00);
        rd(12'hD4, 32'h11);
        rd(12'hE8, 32'h10);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped err", 1, lerr);
        // ratio 52, 48k frames
        audio();
        rd(12'hDC, 32'h09);
        rd(12'hE0, 32'h34);
        chk("invalid", 0, inval);
        chk("irq", 1, irq);
        rd(12'hEC, 32'h3);
        rd(12'hEC, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        // route codes mute, swap, mixed; reserved bits drop
        for (int i = 0; i < 3; i++) begin
            rt = tab[i];
            wr(12'hD4, rt);
            rd(12'hD4, rt & 8'h33);
            audio();
        end
        rt = 8'h11;
        wr(12'hD4, rt);
        wr(12'hD0, 32'h1);
        off = 9'd1;
        audio();
        wr(12'hDC, 32'hFF);
        wr(12'hE0, 32'hFF);
        rd(12'hDC, 32'h09);
        rd(12'hE0, 32'h34);
        // ratio 78, 32k; events masked off
        wr(12'hF0, 32'h0);
        half = 10'd39;
        audio();
        rd(12'hDC, 32'h06);
        rd(12'hE0, 32'h4E);
        chk("irq", 0, irq);
        rd(12'hEC, 32'h7);
        // ratio 26, 96k but below span
        wr(12'hF0, 32'h4);
        wr(12'hD0, 32'h0);
        off = 9'd0;
        half = 10'd13;
        repeat (4) @(negedge frclk);
        rd(12'hDC, 32'h0B);
        rd(12'hE0, 32'h1A);
        chk("invalid", 1, inval);
        chk("irq", 1, irq);
        rd(12'hEC, 32'h7);
        // ratio 562, offset 256 through the high bit
        wr(12'hE8, 32'h1);
        off = 9'd256;
        half = 10'd281;
        audio();
        rd(12'hE8, 32'h11);
        rd(12'hDC, 32'h20);
        rd(12'hE0, 32'h32);
        chk("invalid", 1, inval);
        end_sim();
    end
endmodule // testbench
